// ===== design/cmtb_core.sv
`timescale 1ns/10ps
// Notes on behaviour
// R1 - Lowest-numbered matching available mailbox takes message
// R2 - Receive type locks first message
// R3 - Overwrite type replaces with each message
// R4 - Consumer sends remote, keeps first answer
// R5 - Software chains receive buffers, last overwrites
// R6 - Highest priority transmit mailbox goes first
// R7 - Transmit now or at trigger; report done
// R8 - Producer answers matching remote frame automatically
// R9 - Sixteen-bit timer advances on bit clock
// R10 - Timer clears on reset, sleep, disable, trigger
// R11 - Timer reset strobe clears; value readable
// R12 - Wrap sets overflow flag, read clears
// R13 - Freeze holds timer at all ones
// R14 - Capture timer at frame start or end
// R15 - Mode bit selects timestamp or triggered
// R16 - Quantum from master clock, eight to 25
// R17 - Sync segment is one quantum
// R18 - Propagation segment one to eight quanta
// R19 - Phase one segment one to eight quanta
// R20 - Software keeps phase two within limits
// R21 - Processing time fixed at two quanta
// R22 - Quantum and segments are field plus one
// R23 - Software limits jump width
// R24 - Masked identifier compared for acceptance
// R25 - Status read clears flags, set wins
module cmtb_core (
  input wire logic clk,
  input wire logic srst,
  input wire logic controller_enable,
  input wire logic low_power_request,
  input wire logic timer_freeze_enable,
  input wire logic capture_at_end_select,
  input wire logic time_triggered_select,
  input wire logic timer_reset,
  input wire logic status_read,
  input wire logic [cmtb_pkg::PRESC_W-1:0] quantum_prescaler,
  input wire logic [cmtb_pkg::SEG_W-1:0] propagation_length,
  input wire logic [cmtb_pkg::SEG_W-1:0] phase_one_length,
  input wire logic [cmtb_pkg::SEG_W-1:0] phase_two_length,
  input wire logic [cmtb_pkg::SJW_W-1:0] jump_width,
  input wire logic [cmtb_pkg::NUM_MB*3-1:0] mb_type,
  input wire logic [cmtb_pkg::NUM_MB*cmtb_pkg::PRIO_W-1:0] tx_priority,
  input wire logic [cmtb_pkg::NUM_MB*cmtb_pkg::ID_W-1:0] mb_id,
  input wire logic [cmtb_pkg::NUM_MB*cmtb_pkg::ID_W-1:0] mb_mask,
  input wire logic [cmtb_pkg::NUM_MB*cmtb_pkg::TIMER_W-1:0] mb_trigger,
  input wire logic [cmtb_pkg::NUM_MB-1:0] transfer_request,
  input wire logic [cmtb_pkg::NUM_MB-1:0] abort_request,
  input wire logic [cmtb_pkg::NUM_MB*cmtb_pkg::DATA_W-1:0] mb_tx_data,
  input wire logic frame_start,
  input wire logic frame_end,
  input wire logic rx_valid,
  input wire logic rx_remote,
  input wire logic [cmtb_pkg::ID_W-1:0] rx_id,
  input wire logic [cmtb_pkg::DLC_W-1:0] rx_dlc,
  input wire logic [cmtb_pkg::DATA_W-1:0] rx_data,
  input wire logic tx_ready,
  input wire logic tx_done,
  output logic tx_valid,
  output logic tx_remote,
  output logic [cmtb_pkg::MB_IDX_W-1:0] tx_mailbox,
  output logic [cmtb_pkg::ID_W-1:0] tx_id,
  output logic [cmtb_pkg::DATA_W-1:0] tx_data,
  output logic [cmtb_pkg::NUM_MB-1:0] message_ready,
  output logic [cmtb_pkg::NUM_MB-1:0] message_aborted,
  output logic [cmtb_pkg::NUM_MB*cmtb_pkg::ID_W-1:0] mb_rx_id,
  output logic [cmtb_pkg::NUM_MB*cmtb_pkg::DLC_W-1:0] mb_rx_dlc,
  output logic [cmtb_pkg::NUM_MB*cmtb_pkg::DATA_W-1:0] mb_rx_data,
  output logic [cmtb_pkg::TIMER_W-1:0] timer_value,
  output logic [cmtb_pkg::TIMER_W-1:0] timestamp_value,
  output logic timer_overflow_flag,
  output logic timestamp_flag,
  output logic [cmtb_pkg::TIMER_W-1:0] status_flags_rd,
  output logic tq_tick,
  output logic sample_tick,
  output logic bit_tick,
  output logic timing_config_valid
);
  localparam int N = cmtb_pkg::NUM_MB;
  localparam int IW = cmtb_pkg::ID_W;

  // --------------------------------------------------------------
  // Bit timing and timer
  // --------------------------------------------------------------
  logic overflow_event;
  logic tt_clear;
  logic last_ready_q;

  cmtb_bit_timing u_bit_timing (
    .clk(clk),
    .srst(srst),
    .enable(controller_enable && !low_power_request),
    .quantum_prescaler(quantum_prescaler),
    .propagation_length(propagation_length),
    .phase_one_length(phase_one_length),
    .phase_two_length(phase_two_length),
    .tq_tick(tq_tick),
    .bit_tick(bit_tick),
    .sample_tick(sample_tick),
    .config_valid(timing_config_valid)
  );

  // Last mailbox ready edge restarts timer, in time-triggered mode only
  always_ff @(posedge clk) begin
    if (srst) begin
      last_ready_q <= 1'b0;
    end else begin
      last_ready_q <= message_ready[N-1];
    end
  end
  assign tt_clear = time_triggered_select && message_ready[N-1] && !last_ready_q; // R10

  cmtb_timer u_timer (
    .clk(clk),
    .srst(srst),
    .controller_enable(controller_enable),
    .low_power_request(low_power_request),
    .bit_tick(bit_tick),
    .timer_reset(timer_reset),
    .timer_freeze_enable(timer_freeze_enable),
    .tt_clear(tt_clear),
    .timer_value(timer_value),
    .overflow_event(overflow_event)
  );

  // --------------------------------------------------------------
  // Status flags and timestamp
  // --------------------------------------------------------------
  logic capture;
  assign capture = controller_enable && !time_triggered_select
    && (capture_at_end_select ? frame_end : frame_start); // R14 R15

  always_ff @(posedge clk) begin
    if (srst) begin
      timestamp_value <= '0;
    end else if (capture) begin
      timestamp_value <= timer_value; // R14
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      timer_overflow_flag <= 1'b0;
    end else if (overflow_event) begin // R12 R25
      timer_overflow_flag <= 1'b1;
    end else if (status_read) begin
      timer_overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      timestamp_flag <= 1'b0;
    end else if (capture) begin // R14 R25
      timestamp_flag <= 1'b1;
    end else if (status_read) begin
      timestamp_flag <= 1'b0;
    end
  end

  // Flags seen in the read cycle
  assign status_flags_rd = {14'h0000, timestamp_flag, timer_overflow_flag}; // R25

  // --------------------------------------------------------------
  // Per-mailbox decode
  // --------------------------------------------------------------
  logic [N-1:0] rx_avail;
  logic [N-1:0] rx_match;
  logic [N-1:0] remote_match;
  logic [N-1:0] tx_pending;
  logic [N-1:0] busy_q;
  logic [N-1:0] answer_pending_q;
  logic [N-1:0] prod_armed_q;
  logic [N-1:0] trig_ok;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_mb
      logic [2:0] t;
      logic id_hit;
      assign t = mb_type[g*3 +: 3];
      assign id_hit = ((rx_id & mb_mask[g*IW +: IW]) == (mb_id[g*IW +: IW] & mb_mask[g*IW +: IW])); // R24
      assign rx_avail[g] = (t == cmtb_pkg::CMTB_MOT_RX_OVERWRITE)
        || (busy_q[g] && !message_ready[g] && t == cmtb_pkg::CMTB_MOT_RX) // R2 R3
        || (answer_pending_q[g] && t == cmtb_pkg::CMTB_MOT_CONSUMER); // R4
      assign rx_match[g] = rx_avail[g] && id_hit && !rx_remote;
      assign remote_match[g] = rx_remote && id_hit && t == cmtb_pkg::CMTB_MOT_PRODUCER && busy_q[g]; // R8
      assign trig_ok[g] = !time_triggered_select || (timer_value == mb_trigger[g*16 +: 16]); // R7 R15
      assign tx_pending[g] = busy_q[g] && !answer_pending_q[g] && trig_ok[g]
        && (t == cmtb_pkg::CMTB_MOT_TX || t == cmtb_pkg::CMTB_MOT_CONSUMER
        || (t == cmtb_pkg::CMTB_MOT_PRODUCER && prod_armed_q[g]));
    end
  endgenerate

  // Lowest numbered acceptor
  logic rx_hit;
  logic [cmtb_pkg::MB_IDX_W-1:0] rx_sel;
  always_comb begin
    rx_hit = 1'b0;
    rx_sel = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (rx_match[i]) begin // R1
        rx_hit = 1'b1;
        rx_sel = i[cmtb_pkg::MB_IDX_W-1:0];
      end
    end
  end

  // Larger priority first, lower index on tie
  logic tx_hit;
  logic [cmtb_pkg::MB_IDX_W-1:0] tx_sel;
  logic [cmtb_pkg::PRIO_W-1:0] best_prio;
  always_comb begin
    tx_hit = 1'b0;
    tx_sel = '0;
    best_prio = '0;
    for (int i = 0; i < N; i++) begin
      if (tx_pending[i] && (!tx_hit || tx_priority[i*cmtb_pkg::PRIO_W +: cmtb_pkg::PRIO_W] > best_prio)) begin // R6
        tx_hit = 1'b1;
        tx_sel = i[cmtb_pkg::MB_IDX_W-1:0];
        best_prio = tx_priority[i*cmtb_pkg::PRIO_W +: cmtb_pkg::PRIO_W];
      end
    end
  end

  // --------------------------------------------------------------
  // Transmit handoff
  // --------------------------------------------------------------
  logic launch;
  assign launch = controller_enable && tx_hit && !tx_valid && tx_ready;

  always_ff @(posedge clk) begin
    if (srst || !controller_enable) begin
      tx_valid <= 1'b0;
      tx_remote <= 1'b0;
      tx_mailbox <= '0;
      tx_id <= '0;
      tx_data <= '0;
    end else if (launch) begin
      tx_valid <= 1'b1;
      tx_mailbox <= tx_sel;
      tx_id <= mb_id[tx_sel*IW +: IW];
      tx_data <= mb_tx_data[tx_sel*cmtb_pkg::DATA_W +: cmtb_pkg::DATA_W];
      tx_remote <= (mb_type[tx_sel*3 +: 3] == cmtb_pkg::CMTB_MOT_CONSUMER); // R4
    end else if (tx_done || abort_request[tx_mailbox]) begin
      tx_valid <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Mailbox state and storage
  // --------------------------------------------------------------
  generate
    for (g = 0; g < N; g++) begin : g_st
      logic done_me;
      logic rx_me;
      logic [2:0] t;
      assign t = mb_type[g*3 +: 3];
      assign done_me = tx_valid && tx_done && tx_mailbox == g;
      assign rx_me = controller_enable && rx_valid && rx_hit && rx_sel == g;

      always_ff @(posedge clk) begin
        if (srst || t == cmtb_pkg::CMTB_MOT_DISABLED) begin
          busy_q[g] <= 1'b0;
          answer_pending_q[g] <= 1'b0;
          prod_armed_q[g] <= 1'b0;
          message_ready[g] <= 1'b0;
          message_aborted[g] <= 1'b0;
        end else if (transfer_request[g]) begin // R2 R4
          busy_q[g] <= 1'b1;
          answer_pending_q[g] <= 1'b0;
          prod_armed_q[g] <= 1'b0;
          message_ready[g] <= 1'b0;
          message_aborted[g] <= 1'b0;
        end else begin
          if (rx_me) begin // R2 R3 R4
            message_ready[g] <= 1'b1;
            answer_pending_q[g] <= 1'b0;
            if (t != cmtb_pkg::CMTB_MOT_RX_OVERWRITE) begin
              busy_q[g] <= 1'b0;
            end
          end
          if (controller_enable && rx_valid && remote_match[g]) begin // R8
            prod_armed_q[g] <= 1'b1;
          end
          if (done_me) begin // R7
            if (t == cmtb_pkg::CMTB_MOT_CONSUMER) begin
              answer_pending_q[g] <= 1'b1;
            end else begin
              busy_q[g] <= 1'b0;
              prod_armed_q[g] <= 1'b0;
              message_ready[g] <= 1'b1;
            end
          end else if (abort_request[g] && busy_q[g]) begin // R7
            busy_q[g] <= 1'b0;
            message_aborted[g] <= 1'b1;
          end
        end
      end

      always_ff @(posedge clk) begin
        if (srst) begin
          mb_rx_id[g*IW +: IW] <= '0;
          mb_rx_dlc[g*cmtb_pkg::DLC_W +: cmtb_pkg::DLC_W] <= '0;
          mb_rx_data[g*cmtb_pkg::DATA_W +: cmtb_pkg::DATA_W] <= '0;
        end else if (rx_me) begin // R1
          mb_rx_id[g*IW +: IW] <= rx_id;
          mb_rx_dlc[g*cmtb_pkg::DLC_W +: cmtb_pkg::DLC_W] <= rx_dlc;
          mb_rx_data[g*cmtb_pkg::DATA_W +: cmtb_pkg::DATA_W] <= rx_data;
        end
      end
    end
  endgenerate
endmodule : cmtb_core

// ===== pkg/cmtb_pkg.sv
package cmtb_pkg;
  // --------------------------------------------------------------
  // Sizes
  // --------------------------------------------------------------
  localparam int NUM_MB = 8;
  localparam int MB_IDX_W = 3;
  localparam int ID_W = 29;
  localparam int DATA_W = 64;
  localparam int DLC_W = 4;
  localparam int PRIO_W = 4;
  localparam int TIMER_W = 16;
  localparam logic [15:0] TIMER_MAX = 16'hFFFF;
  localparam logic [15:0] TIMER_RST = 16'h0000;
  // --------------------------------------------------------------
  // Bit timing fields
  // --------------------------------------------------------------
  localparam int PRESC_W = 7;
  localparam int SEG_W = 3;
  localparam int SJW_W = 2;
  localparam int TQ_CNT_W = 5;
  localparam logic [4:0] SYNC_TQ = 5'h01;
  localparam logic [4:0] IPT_TQ = 5'h02;
  localparam logic [4:0] TQ_MIN = 5'h08;
  localparam logic [4:0] TQ_MAX = 5'h19;
  // --------------------------------------------------------------
  // Mailbox object types
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    CMTB_MOT_DISABLED,
    CMTB_MOT_RX,
    CMTB_MOT_RX_OVERWRITE,
    CMTB_MOT_TX,
    CMTB_MOT_CONSUMER,
    CMTB_MOT_PRODUCER
  } cmtb_mot_t;
  typedef enum logic [1:0] {
    CMTB_SEG_SYNC,
    CMTB_SEG_PROP,
    CMTB_SEG_PH1,
    CMTB_SEG_PH2
  } cmtb_seg_t;
endpackage : cmtb_pkg

// ===== design/cmtb_bit_timing.sv
`timescale 1ns/10ps
module cmtb_bit_timing (
  input wire logic clk,
  input wire logic srst,
  input wire logic enable,
  input wire logic [cmtb_pkg::PRESC_W-1:0] quantum_prescaler,
  input wire logic [cmtb_pkg::SEG_W-1:0] propagation_length,
  input wire logic [cmtb_pkg::SEG_W-1:0] phase_one_length,
  input wire logic [cmtb_pkg::SEG_W-1:0] phase_two_length,
  output logic tq_tick,
  output logic bit_tick,
  output logic sample_tick,
  output logic config_valid
);
  // --------------------------------------------------------------
  // Time quantum prescaler
  // --------------------------------------------------------------
  logic [cmtb_pkg::PRESC_W-1:0] presc_q;
  logic [cmtb_pkg::TQ_CNT_W-1:0] tq_in_seg_q;
  logic [cmtb_pkg::TQ_CNT_W-1:0] seg_len;
  logic [cmtb_pkg::TQ_CNT_W-1:0] total_tq;
  cmtb_pkg::cmtb_seg_t seg_q;

  always_ff @(posedge clk) begin
    if (srst || !enable) begin
      presc_q <= '0;
    end else if (presc_q == quantum_prescaler) begin // R22
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + 1'b1;
    end
  end

  assign tq_tick = enable && (presc_q == quantum_prescaler); // R16

  // --------------------------------------------------------------
  // Segment sequencer
  // --------------------------------------------------------------
  always_comb begin
    case (seg_q)
      cmtb_pkg::CMTB_SEG_SYNC: seg_len = cmtb_pkg::SYNC_TQ; // R17
      cmtb_pkg::CMTB_SEG_PROP: seg_len = {2'b00, propagation_length} + 5'h01; // R18
      cmtb_pkg::CMTB_SEG_PH1: seg_len = {2'b00, phase_one_length} + 5'h01; // R19
      default: seg_len = {2'b00, phase_two_length} + 5'h01; // R22
    endcase
  end

  assign total_tq = cmtb_pkg::SYNC_TQ + {2'b00, propagation_length} + {2'b00, phase_one_length}
    + {2'b00, phase_two_length} + 5'h03;
  assign config_valid = (total_tq >= cmtb_pkg::TQ_MIN) && (total_tq <= cmtb_pkg::TQ_MAX)
    && ({2'b00, phase_two_length} + 5'h01 >= cmtb_pkg::IPT_TQ); // R21

  always_ff @(posedge clk) begin
    if (srst || !enable) begin
      seg_q <= cmtb_pkg::CMTB_SEG_SYNC;
      tq_in_seg_q <= '0;
    end else if (tq_tick) begin
      if (tq_in_seg_q + 5'h01 >= seg_len) begin
        tq_in_seg_q <= '0;
        case (seg_q)
          cmtb_pkg::CMTB_SEG_SYNC: seg_q <= cmtb_pkg::CMTB_SEG_PROP;
          cmtb_pkg::CMTB_SEG_PROP: seg_q <= cmtb_pkg::CMTB_SEG_PH1;
          cmtb_pkg::CMTB_SEG_PH1: seg_q <= cmtb_pkg::CMTB_SEG_PH2;
          default: seg_q <= cmtb_pkg::CMTB_SEG_SYNC;
        endcase
      end else begin
        tq_in_seg_q <= tq_in_seg_q + 1'b1;
      end
    end
  end

  assign sample_tick = tq_tick && (seg_q == cmtb_pkg::CMTB_SEG_PH1) && (tq_in_seg_q + 5'h01 >= seg_len);
  assign bit_tick = tq_tick && (seg_q == cmtb_pkg::CMTB_SEG_PH2) && (tq_in_seg_q + 5'h01 >= seg_len);
endmodule : cmtb_bit_timing

// ===== design/cmtb_timer.sv
`timescale 1ns/10ps
module cmtb_timer (
  input wire logic clk,
  input wire logic srst,
  input wire logic controller_enable,
  input wire logic low_power_request,
  input wire logic bit_tick,
  input wire logic timer_reset,
  input wire logic timer_freeze_enable,
  input wire logic tt_clear,
  output logic [cmtb_pkg::TIMER_W-1:0] timer_value,
  output logic overflow_event
);
  // --------------------------------------------------------------
  // Free-running bit clock counter
  // --------------------------------------------------------------
  logic clear;
  logic frozen;
  logic frozen_q;
  assign clear = !controller_enable || low_power_request || timer_reset || tt_clear; // R10 R11
  assign frozen = timer_freeze_enable && (timer_value == cmtb_pkg::TIMER_MAX);
  assign overflow_event = controller_enable && bit_tick && !clear && (timer_value == cmtb_pkg::TIMER_MAX)
    && !(timer_freeze_enable && frozen_q); // R12 R13

  always_ff @(posedge clk) begin
    if (srst || clear) begin
      frozen_q <= 1'b0;
    end else if (bit_tick && frozen) begin
      frozen_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || clear) begin // R10
      timer_value <= cmtb_pkg::TIMER_RST;
    end else if (bit_tick && !frozen) begin // R9 R13
      timer_value <= timer_value + 1'b1;
    end
  end
endmodule : cmtb_timer

// ===== bench/cmtb_engine_model.sv
`timescale 1ns/10ps
module cmtb_engine_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic stall,
  input wire logic [3:0] slow,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic tx_done
);
  // ------------
  // Frame sender
  // ------------
  logic [3:0] cnt_q;
  assign tx_ready = !stall;
  // Done slow+1 cycles after the offer
  assign tx_done = tx_valid && (cnt_q == slow + 4'h1);
  always_ff @(posedge clk) begin
    if (srst || !tx_valid || tx_done) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : cmtb_engine_model

// ===== bench/cmtb_core_props.sv
`timescale 1ns/10ps
module cmtb_core_props (
  input wire logic clk,
  input wire logic srst,
  input wire logic controller_enable,
  input wire logic low_power_request,
  input wire logic timer_freeze_enable,
  input wire logic time_triggered_select,
  input wire logic timer_reset,
  input wire logic status_read,
  input wire logic [6:0] quantum_prescaler,
  input wire logic [2:0] propagation_length,
  input wire logic [2:0] phase_one_length,
  input wire logic [2:0] phase_two_length,
  input wire logic [7:0] transfer_request,
  input wire logic [7:0] abort_request,
  input wire logic tx_done,
  input wire logic tx_valid,
  input wire logic tx_remote,
  input wire logic [2:0] tx_mailbox,
  input wire logic [63:0] tx_data,
  input wire logic [7:0] message_ready,
  input wire logic [15:0] timer_value,
  input wire logic timer_overflow_flag,
  input wire logic timestamp_flag,
  input wire logic [15:0] status_flags_rd,
  input wire logic bit_tick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ------------
  // Helpers
  // ------------
  logic [11:0] gap_q;
  logic seen_q;
  logic run;
  // No clear source
  assign run = controller_enable && !low_power_request && !timer_reset && !time_triggered_select;
  always_ff @(posedge clk) begin
    if (srst || !controller_enable || low_power_request) begin
      gap_q <= 12'h000;
      seen_q <= 1'b0;
    end else if (bit_tick) begin
      gap_q <= 12'h001;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 12'h001;
    end
  end
  a_timer_step: assert property (run && timer_value < 16'hFFFF |=>
    timer_value == $past(timer_value) + {15'h0000, $past(bit_tick)}) else $error("timer step wrong");
  a_timer_clear: assert property (!controller_enable || low_power_request |=> timer_value == 16'h0000)
    else $error("timer not cleared");
  a_reset_strobe: assert property (timer_reset |=> timer_value == 16'h0000)
    else $error("timer reset ignored");
  a_wrap_flag: assert property (run && timer_value == 16'hFFFF && bit_tick && !timer_freeze_enable |=>
    timer_value == 16'h0000 && timer_overflow_flag) else $error("wrap wrong");
  a_freeze_hold: assert property (run && timer_value == 16'hFFFF && timer_freeze_enable |=>
    timer_value == 16'hFFFF) else $error("frozen timer moved");
  a_read_clear: assert property (status_read && timer_value < 16'hFFFE |=> !timer_overflow_flag)
    else $error("overflow flag stuck");
  a_flags_map: assert property (status_flags_rd == {14'h0000, timestamp_flag, timer_overflow_flag})
    else $error("status word wrong");
  a_bit_length: assert property (bit_tick && seen_q |-> gap_q == (12'h001 + quantum_prescaler) *
    (12'h004 + propagation_length + phase_one_length + phase_two_length)) else $error("bit length wrong");
  a_tx_hold: assert property (tx_valid && !tx_done && !abort_request[tx_mailbox]
    && !transfer_request[tx_mailbox] |=> tx_valid && $stable(tx_mailbox) && $stable(tx_data))
    else $error("offered frame changed");
  a_tx_report: assert property (tx_valid && tx_done && !tx_remote && !transfer_request[tx_mailbox]
    |-> ##1 (!tx_valid && message_ready[$past(tx_mailbox)])) else $error("send not reported");
endmodule : cmtb_core_props
bind cmtb_core cmtb_core_props i_props (.*);

// ===== bench/cmtb_core_test.sv
`timescale 1ns/10ps
module cmtb_core_test;
  logic clk = 1'b0, srst = 1'b1, controller_enable = 1'b0, low_power_request = 1'b0, stall = 1'b1;
  logic timer_freeze_enable = 1'b0, capture_at_end_select = 1'b0, time_triggered_select = 1'b0;
  logic timer_reset = 1'b0, status_read = 1'b0, frame_start = 1'b0, frame_end = 1'b0;
  logic rx_valid = 1'b0, rx_remote = 1'b0, tx_ready, tx_done, tx_valid, tx_remote;
  logic [6:0] quantum_prescaler = 7'h01;
  logic [2:0] propagation_length = 3'h1, phase_one_length = 3'h2, phase_two_length = 3'h1;
  logic [1:0] jump_width = 2'h1;
  logic [23:0] mb_type = 24'h0;
  logic [31:0] tx_priority = 32'h0, mb_rx_dlc;
  logic [231:0] mb_id = 232'h0, mb_mask = 232'h0, mb_rx_id;
  logic [127:0] mb_trigger = 128'h0;
  logic [7:0] transfer_request = 8'h00, abort_request = 8'h00, message_ready, message_aborted;
  logic [511:0] mb_tx_data = 512'h0, mb_rx_data;
  logic [28:0] rx_id = 29'h0, tx_id;
  logic [3:0] rx_dlc = 4'h8, slow = 4'h0;
  logic [63:0] rx_data = 64'h0, tx_data;
  logic [2:0] tx_mailbox;
  logic [15:0] timer_value, timestamp_value, status_flags_rd;
  logic timer_overflow_flag, timestamp_flag, tq_tick, sample_tick, bit_tick, timing_config_valid;
  int err_total = 0, n_tests = 0;
  always #2.5 clk = ~clk;
  cmtb_core i_dut (.*);
  cmtb_engine_model i_eng (.clk(clk), .srst(srst), .stall(stall), .slow(slow), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_done(tx_done));
  // ------------
  // Common tasks
  // ------------
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  task automatic wait_tx(input logic v);
    for (int i = 0; i < 400 && tx_valid !== v; i++) @(negedge clk);
    if (tx_valid !== v) begin
      chk(tx_valid, v);
      final_report();
    end
  endtask : wait_tx
  task automatic treq(input logic [7:0] m);
    @(negedge clk);
    transfer_request = m;
    @(negedge clk);
    transfer_request = 8'h00;
  endtask : treq
  task automatic pulse(input logic [3:0] p, output logic [15:0] t);
    {frame_start, frame_end, status_read, timer_reset} = p;
    t = timer_value;
    @(negedge clk);
    {frame_start, frame_end, status_read, timer_reset} = 4'h0;
  endtask : pulse
  task automatic mb(input int i, input logic [2:0] ty, input logic [3:0] pr, input logic [28:0] id);
    mb_type[i*3+:3] = ty;
    tx_priority[i*4+:4] = pr;
    mb_id[i*29+:29] = id;
    mb_mask[i*29+:29] = 29'h1FFFFFFF;
    mb_tx_data[i*64+:64] = {32'hA5A5A5A5, 3'h0, id};
  endtask : mb
  task automatic rx(input logic [28:0] id, input logic rem, input logic [63:0] d);
    @(negedge clk);
    {rx_valid, rx_remote, rx_id, rx_data} = {1'b1, rem, id, d};
    @(negedge clk);
    rx_valid = 1'b0;
    @(negedge clk);
  endtask : rx
  function automatic logic [63:0] rd(input int i);
    return mb_rx_data[i*64+:64];
  endfunction : rd
  // ------------
  // Scenarios
  // ------------
  task automatic t_timing;
    int nc = 0;
    int nq = 0;
    for (int k = 0; k < 100 && bit_tick !== 1'b1; k++) @(negedge clk);
    do begin
      @(negedge clk);
      nc++;
      nq += (tq_tick === 1'b1);
    end while (bit_tick !== 1'b1 && nc < 100);
    chk(nc, 16);
    chk(nq, 8);
    controller_enable = 1'b0;
    {phase_one_length, phase_two_length} = 6'h38;
    @(negedge clk);
    chk(timing_config_valid, 1'b0);
    chk(timer_value, 16'h0000);
    {propagation_length, phase_one_length, phase_two_length} = 9'h1FF;
    @(negedge clk);
    chk(timing_config_valid, 1'b1);
    {propagation_length, phase_one_length, phase_two_length} = 9'h001;
    @(negedge clk);
    chk(timing_config_valid, 1'b0);
    {propagation_length, phase_one_length, phase_two_length} = 9'h051;
    controller_enable = 1'b1;
  endtask : t_timing
  task automatic t_timer;
    logic [15:0] t;
    int k = 0;
    pulse(4'h1, t);
    chk(timer_value, 16'h0000);
    repeat (100) begin
      k += (bit_tick === 1'b1);
      @(negedge clk);
    end
    chk(timer_value, k);
    low_power_request = 1'b1;
    @(negedge clk);
    low_power_request = 1'b0;
    chk(timer_value, 16'h0000);
  endtask : t_timer
  task automatic t_stamp;
    logic [15:0] t;
    pulse(4'h2, t);
    repeat (20) @(negedge clk);
    pulse(4'h8, t);
    chk(timestamp_value, t);
    chk(status_flags_rd, 16'h0002);
    pulse(4'hA, t);
    chk(timestamp_flag, 1'b1);
    pulse(4'h2, t);
    chk(timestamp_flag, 1'b0);
    capture_at_end_select = 1'b1;
    pulse(4'h8, t);
    chk(timestamp_flag, 1'b0);
    repeat (20) @(negedge clk);
    pulse(4'h4, t);
    chk(timestamp_value, t);
    capture_at_end_select = 1'b0;
  endtask : t_stamp
  task automatic t_rx;
    mb(0, cmtb_pkg::CMTB_MOT_RX, 4'h0, 29'h0ABC);
    mb(1, cmtb_pkg::CMTB_MOT_RX, 4'h0, 29'h0ABC);
    mb(2, cmtb_pkg::CMTB_MOT_RX_OVERWRITE, 4'h0, 29'h0ABC);
    mb(3, cmtb_pkg::CMTB_MOT_RX, 4'h0, 29'h0100);
    mb_mask[3*29+:29] = 29'h1FFFFF00;
    treq(8'h0F);
    for (int k = 1; k < 5; k++) rx(29'h0ABC, 1'b0, 64'(k));
    rx(29'h0155, 1'b0, 64'h55);
    chk(rd(3) | rd(2) << 8 | rd(1) << 16 | rd(0) << 24, 64'h01020455);
    chk(mb_rx_id[3*29+:29], 29'h0155);
    chk(message_ready, 8'h0F);
    rx(29'h0ABC, 1'b0, 64'h9);
    chk(rd(0) << 8 | rd(2), 16'h0109);
    treq(8'h01);
    rx(29'h0ABC, 1'b0, 64'h7);
    chk(rd(0), 64'h7);
  endtask : t_rx
  task automatic t_tx;
    int ord[3] = '{5, 6, 4};
    mb(4, cmtb_pkg::CMTB_MOT_TX, 4'h2, 29'h0444);
    mb(5, cmtb_pkg::CMTB_MOT_TX, 4'h9, 29'h0555);
    mb(6, cmtb_pkg::CMTB_MOT_TX, 4'h9, 29'h0666);
    treq(8'h70);
    stall = 1'b0;
    slow = 4'h3;
    foreach (ord[j]) begin
      wait_tx(1'b1);
      chk({tx_mailbox, tx_data}, {3'(ord[j]), 32'hA5A5A5A5, 32'h111 * ord[j]});
      wait_tx(1'b0);
    end
    chk(message_ready[6:4], 3'h7);
    slow = 4'hE;
    treq(8'h10);
    wait_tx(1'b1);
    abort_request = 8'h10;
    @(negedge clk);
    abort_request = 8'h00;
    @(negedge clk);
    chk({message_aborted[4], tx_valid}, 2'h2);
    slow = 4'h0;
  endtask : t_tx
  task automatic t_far;
    mb(1, cmtb_pkg::CMTB_MOT_CONSUMER, 4'h1, 29'h0777);
    treq(8'h02);
    wait_tx(1'b1);
    chk({tx_remote, tx_id}, {1'b1, 29'h0777});
    wait_tx(1'b0);
    rx(29'h0777, 1'b0, 64'h11);
    rx(29'h0777, 1'b0, 64'h22);
    chk(rd(1), 64'h11);
    mb(3, cmtb_pkg::CMTB_MOT_PRODUCER, 4'h1, 29'h0333);
    treq(8'h08);
    repeat (4) @(negedge clk);
    chk(tx_valid, 1'b0);
    rx(29'h0333, 1'b1, 64'h0);
    wait_tx(1'b1);
    chk({tx_mailbox, tx_data}, {3'h3, 32'hA5A5A5A5, 32'h333});
    wait_tx(1'b0);
  endtask : t_far
  task automatic t_tt;
    logic [15:0] t;
    mb(7, cmtb_pkg::CMTB_MOT_RX, 4'h0, 29'h0999);
    treq(8'h80);
    time_triggered_select = 1'b1;
    mb_trigger[4*16+:16] = 16'h0006;
    pulse(4'h1, t);
    treq(8'h10);
    wait_tx(1'b1);
    chk(timer_value, 16'h0006);
    wait_tx(1'b0);
    rx(29'h0999, 1'b0, 64'h99);
    for (int k = 0; k < 4 && timer_value !== 16'h0000; k++) @(negedge clk);
    chk(timer_value, 16'h0000);
    time_triggered_select = 1'b0;
  endtask : t_tt
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    controller_enable = 1'b1;
    t_timing();
    t_timer();
    t_stamp();
    t_rx();
    t_tx();
    t_far();
    t_tt();
    final_report();
  end
endmodule : cmtb_core_test
